// file: design/simd_dup_params.svh
`ifndef SIMD_DUP_PARAMS_SVH
`define SIMD_DUP_PARAMS_SVH

// ****************************************************************
// Feature query
// ****************************************************************
`define FEATURE_QUERY_LEAF 32'h0000_0001
`define FEATURE_PRESENT_BIT 0

// ****************************************************************
// Floating-point control word fields
// ****************************************************************
`define FCW_INVALID_MASK_BIT 0
`define FCW_INEXACT_MASK_BIT 5

// ****************************************************************
// Extended-precision value layout
// ****************************************************************
`define EXT_EXP_BIAS 17'sh03fff
`define EXT_EXP_MAX 15'h7fff
`define EXT_TOP_SHIFT 17'sh0003f

// ****************************************************************
// Memory lines
// ****************************************************************
`define LINE_BYTES 64'h0000_0000_0000_0010
`define LINE_OFFSET_ZERO 4'h0

`endif

// file: design/simd_dup_pkg.sv
package simd_dup_pkg;

   typedef enum logic [3:0] {
      OP_STORE_INT_TRUNCATE_POP = 4'h0,
      OP_UNALIGNED_SPLIT_LOAD = 4'h1,
      OP_DUP_ODD_SINGLES_MOVE = 4'h2,
      OP_DUP_EVEN_SINGLES_MOVE = 4'h3,
      OP_DUP_DOUBLE_MOVE = 4'h4,
      OP_ADDSUB_SINGLE = 4'h5,
      OP_ADDSUB_DOUBLE = 4'h6,
      OP_HORIZ_ADD_SINGLE = 4'h7,
      OP_HORIZ_ADD_DOUBLE = 4'h8,
      OP_HORIZ_SUB_SINGLE = 4'h9,
      OP_HORIZ_SUB_DOUBLE = 4'ha,
      OP_WATCH_ADDRESS = 4'hb,
      OP_WAIT_FOR_WATCHED_STORE = 4'hc,
      OP_FEATURE_QUERY = 4'hd
   } op_t;

   typedef enum logic [1:0] {
      MODE_PROTECTED = 2'h0,
      MODE_COMPAT = 2'h1,
      MODE_LONG64 = 2'h2
   } mode_t;

   typedef enum logic [1:0] {
      SIZE_WORD = 2'h0,
      SIZE_DWORD = 2'h1,
      SIZE_QWORD = 2'h2
   } int_size_t;

   typedef struct packed {
      logic present;
      logic w;
      logic r;
      logic b;
   } ext_prefix_t;

   typedef struct packed {
      op_t op;
      mode_t mode;
      ext_prefix_t prefix;
      logic [2:0] reg_field;
      int_size_t size;
      logic [15:0] fp_control_word;
      logic [79:0] stack_top;
      logic [127:0] vsrc;
      logic [63:0] addr;
      logic [63:0] gp_a;
      logic [63:0] gp_c;
      logic [31:0] leaf;
   } req_t;

   typedef struct packed {
      logic vec_we;
      logic [3:0] vec_idx;
      logic [127:0] vec_data;
      logic gp_we;
      logic [63:0] gp_data;
      logic store_we;
      logic [3:0] store_bytes;
      logic [63:0] store_data;
      logic pop;
      logic fp_invalid;
      logic fp_inexact;
      logic fp_fault;
      logic watch_arm;
      logic wait_req;
      logic [63:0] watch_addr;
      logic [31:0] wait_hint;
      logic [31:0] watch_ext;
      logic deferred;
   } rsp_t;

   function automatic logic [3:0] int_size_bytes(input int_size_t s);
      case (s)
         SIZE_WORD: int_size_bytes = 4'h2;
         SIZE_DWORD: int_size_bytes = 4'h4;
         default: int_size_bytes = 4'h8;
      endcase
   endfunction

endpackage

// file: design/fp_trunc_int.sv
`timescale 1ns/1ps
`default_nettype none
`include "simd_dup_params.svh"

module fp_trunc_int (
   input wire logic [79:0] value,
   input wire simd_dup_pkg::int_size_t size,
   output logic [63:0] result,
   output logic invalid,
   output logic inexact
);

   logic sign;
   logic [14:0] expo;
   logic [63:0] mant;
   logic signed [16:0] unb;
   logic [5:0] sh;
   logic [63:0] mag;
   logic [63:0] lost;
   logic [63:0] limit;
   logic [6:0] top;

   // Rounding control is never consulted: the shift simply drops bits
   always_comb begin
      sign = value[79];
      expo = value[78:64];
      mant = value[63:0];
      unb = signed'({2'b00, expo}) - `EXT_EXP_BIAS;
      sh = 6'h00;
      mag = 64'h0;
      lost = 64'h0;
      invalid = 1'b0;
      top = 7'({simd_dup_pkg::int_size_bytes(size), 3'b000} - 7'h01);
      limit = 64'h1 << top;
      if (expo == `EXT_EXP_MAX) begin
         invalid = 1'b1;
      end else if (unb > `EXT_TOP_SHIFT) begin
         invalid = 1'b1;
      end else if (unb >= 17'sh00000) begin
         sh = 6'(`EXT_TOP_SHIFT - unb);
         mag = mant >> sh;
         lost = mant & ((64'h1 << sh) - 64'h1);
      end else begin
         lost = mant;
      end
      if (mag > limit || (mag == limit && !sign)) begin
         invalid = 1'b1;
      end
      inexact = !invalid && (lost != 64'h0);
      // Integer indefinite for the chosen width on any invalid case
      result = invalid ? limit : (sign ? (~mag + 64'h1) : mag);
   end

endmodule
`default_nettype wire

// file: design/simd_dup_load_truncate_ext.sv
// Overview of operation
// - Feature query leaf 1 returns count register with bit 0 set.
// - Extension has thirteen instructions: ten vector, one stack, two sync.
// - No new architectural state; only transient pipeline holding registers.
// - Watch and wait read general registers and never write them back.
// - In 64-bit mode prefix r bit reaches vector registers 8 to 15.
// - Wide-operand bit selects a 64-bit general register only for the watch address.
// - Prefix ignored where meaningless; instruction runs as if absent.
// - Compatibility mode behaves exactly like protected mode.
// - Vector control/status governs vector math; no new data types.
// - Truncating store chops toward zero, ignores rounding, stores, pops.
// - Truncating store supports 16, 32 and 64 bit destinations.
// - Control word matters only via invalid and inexact exception masks.
// - Aligned split load fetches exactly the sixteen requested bytes.
// - Unaligned split load fetches 32 aligned bytes, extracts sixteen.
// - Odd duplicate writes source elements 3,3,1,1 into lanes 3..0.
// - Even duplicate writes source elements 2,2,0,0 into lanes 3..0.
// - Double duplicate copies 64-bit source into both result halves.
`timescale 1ns/1ps
`default_nettype none
`include "simd_dup_params.svh"

module simd_dup_load_truncate_ext (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic req_valid,
   input wire simd_dup_pkg::req_t req,
   output logic req_ready,
   output logic mem_req_valid,
   output logic [63:0] mem_addr,
   input wire logic mem_req_ready,
   input wire logic mem_rsp_valid,
   input wire logic [127:0] mem_rsp_data,
   output logic rsp_valid,
   output simd_dup_pkg::rsp_t rsp
);

   // ****************************************************************
   // Types and state
   // ****************************************************************
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_REQ_LO = 6'h02,
      S_WAIT_LO = 6'h04,
      S_REQ_HI = 6'h08,
      S_WAIT_HI = 6'h10,
      S_EXEC = 6'h20
   } state_t;

   state_t state_reg;
   state_t state_next;
   simd_dup_pkg::req_t req_reg;
   simd_dup_pkg::rsp_t rsp_reg;
   simd_dup_pkg::rsp_t rsp_next;
   logic rsp_valid_reg;
   logic [63:0] mem_addr_reg;
   logic [255:0] line_reg;
   logic accept;
   logic aligned;
   logic long64;
   logic ext_r;
   logic wide;
   logic [63:0] trunc_val;
   logic trunc_invalid;
   logic trunc_inexact;
   logic [1:0] fetch_cnt_reg;

   function automatic logic [127:0] extract16(input logic [255:0] blk,
                                             input logic [3:0] off);
      logic [255:0] s;
      s = blk >> {off, 3'b000};
      extract16 = s[127:0];
   endfunction

   assign accept = req_valid && req_ready;
   assign req_ready = (state_reg == S_IDLE);
   assign mem_req_valid = (state_reg == S_REQ_LO) || (state_reg == S_REQ_HI);
   assign mem_addr = mem_addr_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp = rsp_reg;

   // Only the 64-bit mode test is made, so compatibility mode takes the
   // protected-mode path with no further gating
   assign long64 = (req_reg.mode == simd_dup_pkg::MODE_LONG64);
   assign ext_r = long64 && req_reg.prefix.present && req_reg.prefix.r;
   assign wide = long64 && req_reg.prefix.present && req_reg.prefix.w;
   assign aligned = (req_reg.addr[3:0] == `LINE_OFFSET_ZERO);

   fp_trunc_int u_trunc (
      .value(req_reg.stack_top),
      .size(req_reg.size),
      .result(trunc_val),
      .invalid(trunc_invalid),
      .inexact(trunc_inexact)
   );

   // ****************************************************************
   // Sequencing
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (req_valid) begin
               if (req.op == simd_dup_pkg::OP_UNALIGNED_SPLIT_LOAD) begin
                  state_next = S_REQ_LO;
               end else begin
                  state_next = S_EXEC;
               end
            end
         end
         S_REQ_LO: begin
            if (mem_req_ready) begin
               state_next = S_WAIT_LO;
            end
         end
         S_WAIT_LO: begin
            if (mem_rsp_valid) begin
               // An aligned request never touches the next line
               state_next = aligned ? S_EXEC : S_REQ_HI;
            end
         end
         S_REQ_HI: begin
            if (mem_req_ready) begin
               state_next = S_WAIT_HI;
            end
         end
         S_WAIT_HI: begin
            if (mem_rsp_valid) begin
               state_next = S_EXEC;
            end
         end
         S_EXEC: begin
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Holding copy of the request; kept after completion until the next accept,
   // nothing here is visible to save or restore
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         req_reg <= '0;
      end else if (accept) begin
         req_reg <= req;
      end
   end

   // ****************************************************************
   // Split load fetch
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mem_addr_reg <= 64'h0;
      end else if (accept) begin
         mem_addr_reg <= {req.addr[63:4], `LINE_OFFSET_ZERO};
      end else if (state_reg == S_WAIT_LO && mem_rsp_valid) begin
         mem_addr_reg <= mem_addr_reg + `LINE_BYTES;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         line_reg <= 256'h0;
      end else if (state_reg == S_WAIT_LO && mem_rsp_valid) begin
         line_reg[127:0] <= mem_rsp_data;
      end else if (state_reg == S_WAIT_HI && mem_rsp_valid) begin
         line_reg[255:128] <= mem_rsp_data;
      end
   end

   // ****************************************************************
   // Result formation
   // ****************************************************************
   always_comb begin
      rsp_next = '0;
      rsp_next.vec_idx = {ext_r, req_reg.reg_field};
      case (req_reg.op)
         simd_dup_pkg::OP_DUP_ODD_SINGLES_MOVE: begin
            rsp_next.vec_we = 1'b1;
            rsp_next.vec_data = {req_reg.vsrc[127:96], req_reg.vsrc[127:96],
               req_reg.vsrc[63:32], req_reg.vsrc[63:32]};
         end
         simd_dup_pkg::OP_DUP_EVEN_SINGLES_MOVE: begin
            rsp_next.vec_we = 1'b1;
            rsp_next.vec_data = {req_reg.vsrc[95:64], req_reg.vsrc[95:64],
               req_reg.vsrc[31:0], req_reg.vsrc[31:0]};
         end
         simd_dup_pkg::OP_DUP_DOUBLE_MOVE: begin
            // Raw bit copy: the vector control/status has no say over moves
            rsp_next.vec_we = 1'b1;
            rsp_next.vec_data = {req_reg.vsrc[63:0],
               req_reg.vsrc[63:0]};
         end
         simd_dup_pkg::OP_UNALIGNED_SPLIT_LOAD: begin
            rsp_next.vec_we = 1'b1;
            rsp_next.vec_data = extract16(line_reg,
               req_reg.addr[3:0]);
         end
         simd_dup_pkg::OP_STORE_INT_TRUNCATE_POP: begin
            rsp_next.fp_invalid = trunc_invalid;
            rsp_next.fp_inexact = trunc_inexact;
            rsp_next.store_bytes =
               simd_dup_pkg::int_size_bytes(req_reg.size);
            // Unmasked invalid leaves memory and the stack untouched
            if (trunc_invalid &&
                !req_reg.fp_control_word[`FCW_INVALID_MASK_BIT]) begin
               rsp_next.fp_fault = 1'b1;
            end else begin
               rsp_next.store_we = 1'b1;
               rsp_next.store_data = trunc_val;
               rsp_next.pop = 1'b1;
               rsp_next.fp_fault = trunc_inexact &&
                  !req_reg.fp_control_word[`FCW_INEXACT_MASK_BIT];
            end
         end
         simd_dup_pkg::OP_WATCH_ADDRESS: begin
            rsp_next.watch_arm = 1'b1;
            rsp_next.watch_addr = wide ? req_reg.gp_a :
               {32'h0, req_reg.gp_a[31:0]};
            rsp_next.watch_ext = req_reg.gp_c[31:0];
            rsp_next.wait_hint = 32'h0;
         end
         simd_dup_pkg::OP_WAIT_FOR_WATCHED_STORE: begin
            rsp_next.wait_req = 1'b1;
            rsp_next.wait_hint = req_reg.gp_a[31:0];
            rsp_next.watch_ext = req_reg.gp_c[31:0];
         end
         simd_dup_pkg::OP_FEATURE_QUERY: begin
            rsp_next.gp_we = 1'b1;
            if (req_reg.leaf == `FEATURE_QUERY_LEAF) begin
               rsp_next.gp_data[`FEATURE_PRESENT_BIT] = 1'b1;
            end
         end
         default: begin
            // Packed and horizontal add/sub run in the FP unit
            rsp_next.deferred = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rsp_reg <= '0;
      end else if (state_reg == S_EXEC) begin
         rsp_reg <= rsp_next;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rsp_valid_reg <= 1'b0;
      end else begin
         rsp_valid_reg <= (state_reg == S_EXEC);
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fetch_cnt_reg <= 2'h0;
      end else if (accept) begin
         fetch_cnt_reg <= 2'h0;
      end else if (mem_req_valid && mem_req_ready) begin
         fetch_cnt_reg <= fetch_cnt_reg + 2'h1;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   a_query_present_bit: assert property (
      accept && req.op == simd_dup_pkg::OP_FEATURE_QUERY &&
      req.leaf == `FEATURE_QUERY_LEAF
      |-> ##2 rsp_valid && rsp.gp_we && rsp.gp_data[0])
      else $error("feature query did not report presence");

   a_sync_no_gp_write: assert property (
      rsp_valid && (req_reg.op == simd_dup_pkg::OP_WATCH_ADDRESS ||
      req_reg.op == simd_dup_pkg::OP_WAIT_FOR_WATCHED_STORE)
      |-> !rsp.gp_we)
      else $error("sync instruction wrote a general register");

   a_vec_index_ext: assert property (
      rsp_valid && rsp.vec_we
      |-> rsp.vec_idx == {req_reg.mode == simd_dup_pkg::MODE_LONG64 &&
      req_reg.prefix.present && req_reg.prefix.r, req_reg.reg_field})
      else $error("vector register index wrong");

   a_watch_addr_width: assert property (
      rsp_valid && rsp.watch_arm && wide |-> rsp.watch_addr == req_reg.gp_a)
      else $error("wide watch address truncated");

   a_prefix_ignored: assert property (
      rsp_valid && rsp.watch_arm && !wide |-> rsp.watch_addr[63:32] == 32'h0)
      else $error("meaningless prefix changed the result");

   a_compat_as_protected: assert property (
      rsp_valid && req_reg.mode != simd_dup_pkg::MODE_LONG64
      |-> !rsp.vec_idx[3] && rsp.watch_addr[63:32] == 32'h0)
      else $error("compatibility mode reached 64-bit resources");

   a_trunc_store_pop: assert property (
      rsp_valid && req_reg.op == simd_dup_pkg::OP_STORE_INT_TRUNCATE_POP &&
      !rsp.fp_invalid |-> rsp.store_we && rsp.pop && rsp.store_data == trunc_val)
      else $error("truncating store did not store and pop");

   a_trunc_size: assert property (
      rsp_valid && rsp.store_we
      |-> rsp.store_bytes == {req_reg.size == simd_dup_pkg::SIZE_QWORD,
      req_reg.size == simd_dup_pkg::SIZE_DWORD,
      req_reg.size == simd_dup_pkg::SIZE_WORD, 1'b0})
      else $error("store size wrong");

   a_invalid_unmasked: assert property (
      rsp_valid && rsp.fp_invalid && !req_reg.fp_control_word[`FCW_INVALID_MASK_BIT]
      |-> rsp.fp_fault && !rsp.store_we && !rsp.pop)
      else $error("unmasked invalid still stored");

   a_fetch_count: assert property (
      rsp_valid && req_reg.op == simd_dup_pkg::OP_UNALIGNED_SPLIT_LOAD
      |-> fetch_cnt_reg == (aligned ? 2'h1 : 2'h2))
      else $error("split load fetched wrong number of lines");

   a_split_hi_line: assert property (
      state_reg == S_WAIT_LO && mem_rsp_valid && !aligned
      |=> mem_req_valid && mem_addr == {req_reg.addr[63:4], 4'h0} + 64'h10)
      else $error("second line not at next aligned address");

   a_dup_odd_lanes: assert property (
      accept && req.op == simd_dup_pkg::OP_DUP_ODD_SINGLES_MOVE
      |-> ##2 rsp_valid && rsp.vec_data[31:0] == $past(req.vsrc[63:32], 2)
      && rsp.vec_data[127:96] == $past(req.vsrc[127:96], 2))
      else $error("odd duplicate lanes wrong");

   a_dup_even_lanes: assert property (
      rsp_valid && req_reg.op == simd_dup_pkg::OP_DUP_EVEN_SINGLES_MOVE
      |-> rsp.vec_data[63:32] == req_reg.vsrc[31:0]
      && rsp.vec_data[95:64] == req_reg.vsrc[95:64])
      else $error("even duplicate lanes wrong");

   a_dup_double_halves: assert property (
      rsp_valid && req_reg.op == simd_dup_pkg::OP_DUP_DOUBLE_MOVE
      |-> rsp.vec_data[127:64] == rsp.vec_data[63:0]
      && rsp.vec_data[63:0] == req_reg.vsrc[63:0])
      else $error("double duplicate halves differ");

   c_split_unaligned: cover property (
      rsp_valid && req_reg.op == simd_dup_pkg::OP_UNALIGNED_SPLIT_LOAD &&
      !aligned);
   c_trunc_inexact: cover property (rsp_valid && rsp.fp_inexact);
   c_back_to_back: cover property (rsp_valid && accept);

endmodule
`default_nettype wire

// file: dv/simd_dup_load_truncate_ext_tb.sv
`timescale 1ns/1ps
`default_nettype none
module simd_dup_load_truncate_ext_tb;
   logic clk_sys, reset, req_valid, req_ready;
   logic mem_req_valid, mem_req_ready, mem_rsp_valid, rsp_valid, pend;
   logic [63:0] mem_addr, pend_addr, first_addr;
   logic [127:0] mem_rsp_data, e;
   simd_dup_pkg::req_t req, r;
   simd_dup_pkg::rsp_t rsp;
   int n_errors, cmp_count, lat, n_reads;
   typedef struct {
      simd_dup_pkg::op_t op;
      simd_dup_pkg::mode_t mode;
      logic r;
      logic [127:0] exp;
      logic [3:0] idx;
   } row_t;
   row_t rows[6];
   localparam logic [127:0] SRC = 128'hdddddddd_cccccccc_bbbbbbbb_aaaaaaaa;
   logic [63:0] masks[3] = '{64'hffff, 64'hffff_ffff, '1};
   logic [15:0] fcws[3] = '{16'h037f, 16'h077f, 16'h0b7f};
   logic [63:0] addrs[3] = '{64'h1000, 64'h1007, 64'h100f};

   simd_dup_load_truncate_ext u_dut (
      .clk_sys(clk_sys),
      .reset(reset),
      .req_valid(req_valid),
      .req(req),
      .req_ready(req_ready),
      .mem_req_valid(mem_req_valid),
      .mem_addr(mem_addr),
      .mem_req_ready(mem_req_ready),
      .mem_rsp_valid(mem_rsp_valid),
      .mem_rsp_data(mem_rsp_data),
      .rsp_valid(rsp_valid),
      .rsp(rsp)
   );

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ****************************************************************
   // Memory side: stalls every other cycle, byte i of a line is addr+i
   // ****************************************************************
   always @(posedge clk_sys) begin
      mem_req_ready <= ~mem_req_ready;
      mem_rsp_valid <= pend;
      pend <= !pend && mem_req_valid && mem_req_ready;
      if (pend) begin
         for (int i = 0; i < 16; i++) begin
            mem_rsp_data[8*i+:8] <= pend_addr[7:0] + 8'(i);
         end
      end else begin
         // Idle data keeps moving so a stale line is never mistaken for good
         mem_rsp_data <= ~mem_rsp_data;
      end
      if (!pend && mem_req_valid && mem_req_ready) begin
         pend_addr <= mem_addr;
         if (n_reads == 0) begin
            first_addr <= mem_addr;
         end
         n_reads <= n_reads + 1;
      end
   end

   task automatic check(input string what, input logic [127:0] seen,
                        input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic simd_dup_pkg::req_t mk(input simd_dup_pkg::op_t op,
                                             input simd_dup_pkg::mode_t m);
      mk = '0;
      mk.op = op;
      mk.mode = m;
      mk.fp_control_word = 16'h037f;
   endfunction

   // Offer a request, hold it until taken, then wait for the answer
   task automatic run(input simd_dup_pkg::req_t q);
      int i;
      @(posedge clk_sys);
      req <= q;
      req_valid <= 1'b1;
      @(negedge clk_sys);
      for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk_sys);
      @(posedge clk_sys);
      req_valid <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk_sys);
         lat++;
      end while (rsp_valid !== 1'b1 && lat < 50);
      if (i >= 50 || lat >= 50) begin
         n_errors++;
         wrap_up();
      end
   endtask

   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      pend = 1'b0;
      mem_req_ready = 1'b0;
      mem_rsp_valid = 1'b0;
      mem_rsp_data = '0;
      n_reads = 0;
      rows[0] = '{simd_dup_pkg::OP_DUP_ODD_SINGLES_MOVE,
                  simd_dup_pkg::MODE_PROTECTED, 1'b1,
                  128'hdddddddd_dddddddd_bbbbbbbb_bbbbbbbb, 4'h5};
      rows[1] = '{simd_dup_pkg::OP_DUP_ODD_SINGLES_MOVE,
                  simd_dup_pkg::MODE_LONG64, 1'b1,
                  128'hdddddddd_dddddddd_bbbbbbbb_bbbbbbbb, 4'hd};
      rows[2] = '{simd_dup_pkg::OP_DUP_EVEN_SINGLES_MOVE,
                  simd_dup_pkg::MODE_COMPAT, 1'b1,
                  128'hcccccccc_cccccccc_aaaaaaaa_aaaaaaaa, 4'h5};
      rows[3] = '{simd_dup_pkg::OP_DUP_EVEN_SINGLES_MOVE,
                  simd_dup_pkg::MODE_LONG64, 1'b0,
                  128'hcccccccc_cccccccc_aaaaaaaa_aaaaaaaa, 4'h5};
      rows[4] = '{simd_dup_pkg::OP_DUP_DOUBLE_MOVE,
                  simd_dup_pkg::MODE_LONG64, 1'b1,
                  128'hbbbbbbbb_aaaaaaaa_bbbbbbbb_aaaaaaaa, 4'hd};
      rows[5] = '{simd_dup_pkg::OP_DUP_DOUBLE_MOVE,
                  simd_dup_pkg::MODE_PROTECTED, 1'b0,
                  128'hbbbbbbbb_aaaaaaaa_bbbbbbbb_aaaaaaaa, 4'h5};
      repeat (12) @(posedge clk_sys);
      check("ready in reset", req_ready, 1'b1);
      check("mem valid in reset", mem_req_valid, 1'b0);
      check("rsp valid in reset", rsp_valid, 1'b0);
      check("rsp in reset", rsp === '0, 1'b1);
      reset <= 1'b0;
      $display("test reset done");
      foreach (rows[k]) begin
         r = mk(rows[k].op, rows[k].mode);
         r.prefix = {1'b1, 1'b0, rows[k].r, 1'b0};
         r.reg_field = 3'h5;
         r.vsrc = SRC;
         run(r);
         check("move data", rsp.vec_data, rows[k].exp);
         check("move index", rsp.vec_idx, rows[k].idx);
         check("move we", rsp.vec_we, 1'b1);
         check("move latency", lat, 2);
      end
      $display("test moves done");
      for (int k = 0; k < 2; k++) begin
         r = mk(simd_dup_pkg::OP_FEATURE_QUERY, simd_dup_pkg::MODE_PROTECTED);
         r.leaf = 32'(k + 1);
         run(r);
         check("query", rsp.gp_data, (k == 0) ? 64'h1 : 64'h0);
      end
      $display("test query done");
      for (int k = 0; k < 2; k++) begin
         r = mk(simd_dup_pkg::OP_WATCH_ADDRESS,
                (k == 0) ? simd_dup_pkg::MODE_LONG64
                         : simd_dup_pkg::MODE_PROTECTED);
         r.prefix = 4'hc;
         r.gp_a = 64'h1234_5678_9abc_def0;
         run(r);
         check("watch addr", rsp.watch_addr,
               (k == 0) ? r.gp_a : 64'h9abc_def0);
         check("watch arm", rsp.watch_arm, 1'b1);
         check("watch gp we", rsp.gp_we, 1'b0);
      end
      r = mk(simd_dup_pkg::OP_WAIT_FOR_WATCHED_STORE,
             simd_dup_pkg::MODE_LONG64);
      r.gp_a = 64'h5;
      r.gp_c = 64'h3;
      run(r);
      check("wait req", rsp.wait_req, 1'b1);
      check("wait hint", rsp.wait_hint, 32'h5);
      check("wait ext", rsp.watch_ext, 32'h3);
      check("wait gp we", rsp.gp_we, 1'b0);
      $display("test sync done");
      // -2.75 must give -2 whatever rounding the control word asks for
      for (int k = 0; k < 3; k++) begin
         r = mk(simd_dup_pkg::OP_STORE_INT_TRUNCATE_POP,
                simd_dup_pkg::MODE_PROTECTED);
         r.size = simd_dup_pkg::int_size_t'(2'(k));
         r.fp_control_word = fcws[k];
         r.stack_top = {1'b1, 15'h4000, 64'hb000_0000_0000_0000};
         run(r);
         check("trunc data", rsp.store_data & masks[k],
               64'hffff_ffff_ffff_fffe & masks[k]);
         check("trunc bytes", rsp.store_bytes, 4'h2 << k);
         check("trunc pop", {rsp.store_we, rsp.pop, rsp.fp_inexact,
                             rsp.fp_fault}, 4'he);
      end
      r.fp_control_word = 16'h035f;
      run(r);
      check("inexact unmasked", {rsp.store_we, rsp.pop, rsp.fp_fault},
            3'h7);
      r.size = simd_dup_pkg::SIZE_WORD;
      r.stack_top = {1'b0, 15'h4027, 64'h8000_0000_0000_0000};
      r.fp_control_word = 16'h037f;
      run(r);
      check("invalid masked", rsp.store_data[15:0], 16'h8000);
      check("invalid masked pop", rsp.pop, 1'b1);
      r.fp_control_word = 16'h037e;
      run(r);
      check("invalid unmasked", {rsp.store_we, rsp.pop, rsp.fp_invalid,
                                 rsp.fp_fault}, 4'h3);
      $display("test truncate done");
      foreach (addrs[k]) begin
         r = mk(simd_dup_pkg::OP_UNALIGNED_SPLIT_LOAD,
                simd_dup_pkg::MODE_PROTECTED);
         r.addr = addrs[k];
         n_reads <= 0;
         run(r);
         for (int i = 0; i < 16; i++) e[8*i+:8] = addrs[k][7:0] + 8'(i);
         check("load data", rsp.vec_data, e);
         check("load reads", n_reads, (k == 0) ? 1 : 2);
         check("load line", first_addr, addrs[k] & ~64'hf);
      end
      $display("test split load done");
      for (int k = 5; k < 11; k++) begin
         r = mk(simd_dup_pkg::op_t'(4'(k)), simd_dup_pkg::MODE_PROTECTED);
         r.vsrc = SRC;
         run(r);
         check("deferred", {rsp.deferred, rsp.vec_we}, 2'h2);
      end
      $display("test deferred done");
      // Reset while a line read is wanted: the unit must drop it and idle
      r = mk(simd_dup_pkg::OP_UNALIGNED_SPLIT_LOAD,
             simd_dup_pkg::MODE_PROTECTED);
      r.addr = 64'h2008;
      @(posedge clk_sys);
      req <= r;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      @(negedge clk_sys);
      check("load wanted", mem_req_valid, 1'b1);
      @(posedge clk_sys);
      reset <= 1'b1;
      @(negedge clk_sys);
      check("ready mid reset", req_ready, 1'b1);
      check("mem valid mid reset", mem_req_valid, 1'b0);
      check("rsp valid mid reset", rsp_valid, 1'b0);
      check("rsp mid reset", rsp === '0, 1'b1);
      @(posedge clk_sys);
      reset <= 1'b0;
      r = mk(simd_dup_pkg::OP_DUP_ODD_SINGLES_MOVE,
             simd_dup_pkg::MODE_PROTECTED);
      r.vsrc = SRC;
      run(r);
      check("move after reset", rsp.vec_data, rows[0].exp);
      check("latency after reset", lat, 2);
      $display("test mid reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
